// ---- logic/fsm_pkg.sv ----
// Package for the fault status mirror latches: offsets, bit positions, reset values and carriers.
package fsm_pkg;

  // Register offsets as seen by the serial register port
  localparam logic [7:0] FSM_OFS_SECOND = 8'h2b;
  localparam logic [7:0] FSM_OFS_THIRD  = 8'h2c;

  // Reset value of both mirror registers
  localparam logic [7:0] FSM_RST_FLAGS = 8'h00;

  // Bit positions in fault_flags_second
  localparam int FSM_B2_SHARE     = 7;
  localparam int FSM_B2_ORSWITCH  = 6;
  localparam int FSM_B2_REVERSE   = 5;
  localparam int FSM_B2_SUPPLY    = 4;
  localparam int FSM_B2_GROUND    = 3;
  localparam int FSM_B2_INTREF    = 2;
  localparam int FSM_B2_EXTREF    = 1;
  localparam int FSM_B2_SUPPLY_OV = 0;

  // Bit positions in fault_flags_third
  localparam int FSM_B3_AC_OK     = 7;
  localparam int FSM_B3_PWR_REQ   = 6;
  localparam int FSM_B3_PWR_EN    = 5;
  localparam int FSM_B3_PWR_LINK  = 4;
  localparam int FSM_B3_DC_OK     = 3;
  localparam int FSM_B3_OVERCURR  = 2;
  localparam int FSM_B3_PULSE     = 1;
  localparam int FSM_B3_SUMMARY   = 0;

  // Fault sources of the second register, active high
  typedef struct packed {
    logic share;
    logic or_switch;
    logic reverse;
    logic supply;
    logic ground;
    logic int_ref;
    logic ext_ref;
    logic supply_ov;
  } fsm_src2_s;

  // Fault sources of the third register, active high
  typedef struct packed {
    logic ac_ok;
    logic power_on_request;
    logic power_enable;
    logic power_on_link;
    logic dc_ok;
    logic overcurrent;
    logic pulse;
    logic summary;
  } fsm_src3_s;

  // Register access request from the serial interface logic
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fsm_req_s;

endpackage : fsm_pkg

// ---- logic/fsm_latch_bank.sv ----
// One bank of sticky fault latches with rising-edge set and read-to-clear.
`timescale 1ns/1ps
module fsm_latch_bank #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // Fault sources and read strobe
  input  wire logic [WIDTH-1:0] src,
  input  wire logic             rd_clear,
  // Latched flags
  output logic      [WIDTH-1:0] flags_q
);
  import fsm_pkg::*;

  logic      [WIDTH-1:0] src_prev_q;
  wire logic [WIDTH-1:0] flags_d;

  // Flags come from a byte-wide reset value, so wider banks cannot be served
  if (WIDTH < 1 || WIDTH > $bits(FSM_RST_FLAGS)) begin : g_bad_width
    $error("fsm_latch_bank: WIDTH must be 1 to 8");
  end

  // Previous source level, for edge detection; reset to inactive so a fault
  // present at power-on still counts as an edge once released from reset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      src_prev_q <= '0;
    end else begin
      src_prev_q <= src;
    end
  end

  // Per-bit next value; an edge in the read cycle wins over the clear, so a
  // fault that starts during the read is never lost
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    assign flags_d[i] = (src[i] && !src_prev_q[i]) ? 1'b1 :
                        (rd_clear && !src[i])      ? 1'b0 :
                        flags_q[i];
  end

  // Flag register, one writer for the whole bank
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flags_q <= FSM_RST_FLAGS[WIDTH-1:0];
    end else begin
      flags_q <= flags_d;
    end
  end

endmodule : fsm_latch_bank

// ---- logic/fsm_status_mirror.sv ----
// Top of the fault status mirror: two read-to-clear flag registers behind the register port.
`timescale 1ns/1ps

// Notes on behaviour
// - Second register bits 7..0: share, or-switch, reverse, supply, ground, intref, extref, supply-ov.
// - Third register bits 7..0: ac-ok, power request, enable, link, dc-ok, overcurrent, pulse, summary.
// - Second register resets to all zeros.
// - Third register resets to all zeros.
// - A flag sets only on an inactive-to-active edge of its source.
// - Reading a register clears its latched flags.
// - A flag whose fault is still present survives the read.
module fsm_status_mirror (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // Fault sources
  input  wire fsm_pkg::fsm_src2_s src2,
  input  wire fsm_pkg::fsm_src3_s src3,
  // Register access from the serial interface
  input  wire fsm_pkg::fsm_req_s  req,
  // Read data and hit indication
  output logic      [7:0]       rdata_q,
  output logic                  hit
);
  import fsm_pkg::*;

  // Register map served here, read-only, read-to-clear
  //   fault_flags_second at FSM_OFS_SECOND
  //     7 share fault
  //     6 or-switch fault
  //     5 reverse current fault
  //     4 supply fault
  //     3 ground fault
  //     2 internal reference fault
  //     1 external reference fault
  //     0 supply overvoltage
  //   fault_flags_third at FSM_OFS_THIRD
  //     7 ac-ok fault
  //     6 power-on request fault
  //     5 power-enable fault
  //     4 power-on link fault
  //     3 dc-ok fault
  //     2 overcurrent flag
  //     1 pulse fault
  //     0 summary fault latch
  // Other offsets read as zero and clear nothing; writes change nothing.
  // A flag held by a persisting fault survives the first read, so the host
  // has to read twice after the fault has gone to see it drop.

  // Flag byte width, taken from the carriers so both banks stay in step
  localparam int FLAG_W = $bits(fsm_src2_s);

  // Value returned for a read of an offset that is not mapped here
  localparam logic [FLAG_W-1:0] UNMAPPED_DATA = '0;

  // Register addressed by a read; none for writes and idle cycles
  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_SECOND,
    SEL_THIRD
  } fsm_sel_e;

  // One-hot mask of a bit position; a position outside the byte gives zero
  function automatic logic [FLAG_W-1:0] pos_mask(input int pos);
    logic [FLAG_W-1:0] m;
    m = '0;
    if (pos >= 0 && pos < FLAG_W) begin
      m[pos] = 1'b1;
    end
    return m;
  endfunction : pos_mask

  // Eight positions fill the byte only if all are distinct and in range
  localparam logic [FLAG_W-1:0] MAP2_MASK = pos_mask(FSM_B2_SHARE)
                                          | pos_mask(FSM_B2_ORSWITCH)
                                          | pos_mask(FSM_B2_REVERSE)
                                          | pos_mask(FSM_B2_SUPPLY)
                                          | pos_mask(FSM_B2_GROUND)
                                          | pos_mask(FSM_B2_INTREF)
                                          | pos_mask(FSM_B2_EXTREF)
                                          | pos_mask(FSM_B2_SUPPLY_OV);
  localparam logic [FLAG_W-1:0] MAP3_MASK = pos_mask(FSM_B3_AC_OK)
                                          | pos_mask(FSM_B3_PWR_REQ)
                                          | pos_mask(FSM_B3_PWR_EN)
                                          | pos_mask(FSM_B3_PWR_LINK)
                                          | pos_mask(FSM_B3_DC_OK)
                                          | pos_mask(FSM_B3_OVERCURR)
                                          | pos_mask(FSM_B3_PULSE)
                                          | pos_mask(FSM_B3_SUMMARY);

  // Elaboration checks: a broken map or offset table would alias two flags
  if (MAP2_MASK != '1) begin : g_bad_map2
    $error("fsm_status_mirror: second register bit map is not one-to-one");
  end
  if (MAP3_MASK != '1) begin : g_bad_map3
    $error("fsm_status_mirror: third register bit map is not one-to-one");
  end
  if (FSM_OFS_SECOND == FSM_OFS_THIRD) begin : g_bad_ofs
    $error("fsm_status_mirror: both registers share one offset");
  end
  if ($bits(fsm_src3_s) != FLAG_W || $bits(FSM_RST_FLAGS) != FLAG_W) begin : g_bad_width
    $error("fsm_status_mirror: carriers and reset value differ in width");
  end

  logic [7:0] flags2_q;
  logic [7:0] flags3_q;
  logic [7:0] src2_v;
  logic [7:0] src3_v;
  logic       rd2;
  logic       rd3;
  fsm_sel_e   sel;
  logic [7:0] rdata_d;

  // Address match, used for both decode and the hit output
  function automatic logic is_ofs(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction : is_ofs

  // Offset to register select, shared by the read path
  function automatic fsm_sel_e decode_ofs(input logic [7:0] a);
    fsm_sel_e s;
    s = SEL_NONE;
    if (is_ofs(a, FSM_OFS_SECOND)) begin
      s = SEL_SECOND;
    end else if (is_ofs(a, FSM_OFS_THIRD)) begin
      s = SEL_THIRD;
    end
    return s;
  endfunction : decode_ofs

  // Second register sources, each at its flag bit position
  always_comb begin
    src2_v                   = '0;
    src2_v[FSM_B2_SHARE]     = src2.share;
    src2_v[FSM_B2_ORSWITCH]  = src2.or_switch;
    src2_v[FSM_B2_REVERSE]   = src2.reverse;
    src2_v[FSM_B2_SUPPLY]    = src2.supply;
    src2_v[FSM_B2_GROUND]    = src2.ground;
    src2_v[FSM_B2_INTREF]    = src2.int_ref;
    src2_v[FSM_B2_EXTREF]    = src2.ext_ref;
    src2_v[FSM_B2_SUPPLY_OV] = src2.supply_ov;
  end

  // Third register sources, each at its flag bit position
  always_comb begin
    src3_v                   = '0;
    src3_v[FSM_B3_AC_OK]     = src3.ac_ok;
    src3_v[FSM_B3_PWR_REQ]   = src3.power_on_request;
    src3_v[FSM_B3_PWR_EN]    = src3.power_enable;
    src3_v[FSM_B3_PWR_LINK]  = src3.power_on_link;
    src3_v[FSM_B3_DC_OK]     = src3.dc_ok;
    src3_v[FSM_B3_OVERCURR]  = src3.overcurrent;
    src3_v[FSM_B3_PULSE]     = src3.pulse;
    src3_v[FSM_B3_SUMMARY]   = src3.summary;
  end

  // Only reads clear; the write strobe is never decoded
  assign rd2 = req.rd && is_ofs(req.addr, FSM_OFS_SECOND);
  assign rd3 = req.rd && is_ofs(req.addr, FSM_OFS_THIRD);
  assign hit = is_ofs(req.addr, FSM_OFS_SECOND) || is_ofs(req.addr, FSM_OFS_THIRD);

  // Writes: req.wr and req.wdata are left undecoded on purpose. Every flag is
  // read-only, so a write can neither set nor clear one, while a write to a
  // mapped offset still raises hit so the serial side can acknowledge it.

  // Timing per bank: a source edge sampled on one clock sets the flag there;
  // a read sampled on a later edge returns the flag byte on the next cycle
  // and, on that same edge, clears every flag whose source is low. An edge
  // meeting the read wins, so nothing is lost between snapshot and clear.
  // Second register bank
  fsm_latch_bank #(.WIDTH(FLAG_W)) u_second (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .src      (src2_v),
    .rd_clear (rd2),
    .flags_q  (flags2_q)
  );

  // Third register bank
  fsm_latch_bank #(.WIDTH(FLAG_W)) u_third (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .src      (src3_v),
    .rd_clear (rd3),
    .flags_q  (flags3_q)
  );

  // Read select; only a read strobe picks a register
  always_comb begin
    sel = SEL_NONE;
    if (req.rd) begin
      sel = decode_ofs(req.addr);
    end
  end

  // Next read data is the pre-clear flag byte, so the host sees what it clears.
  // The byte holds between reads; a write never reaches this path.
  always_comb begin
    rdata_d = rdata_q;
    case (sel)
      SEL_SECOND: begin
        rdata_d = flags2_q;
      end
      SEL_THIRD: begin
        rdata_d = flags3_q;
      end
      default: begin
        if (req.rd) begin
          rdata_d = UNMAPPED_DATA;                                       // Unmapped reads return zero
        end
      end
    endcase
  end

  // Read data register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rdata_q <= FSM_RST_FLAGS;
    end else begin
      rdata_q <= rdata_d;
    end
  end

endmodule : fsm_status_mirror

// ---- verification/fsm_status_mirror_monitor.sv ----
// Checker bound to the fault status mirror top.
`timescale 1ns/1ps
module fsm_status_mirror_monitor (
  // Clock and reset
  input wire logic               clk_sys,
  input wire logic               rst,
  // Watched ports
  input wire fsm_pkg::fsm_src2_s src2,
  input wire fsm_pkg::fsm_src3_s src3,
  input wire fsm_pkg::fsm_req_s  req,
  input wire logic [7:0]         rdata_q,
  input wire logic               hit
);
  import fsm_pkg::*;
  // Reads decoded per register
  wire logic r2 = req.rd && req.addr == FSM_OFS_SECOND;
  wire logic r3 = req.rd && req.addr == FSM_OFS_THIRD;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // A source high before a read must show; a fault-free pair of reads must clear
  property p_keep2; r2 && !$past(rst) |=> (rdata_q & $past(src2, 2)) == $past(src2, 2); endproperty
  a_keep2: assert property (p_keep2) else $error("second flag lost");
  property p_keep3; r3 && !$past(rst) |=> (rdata_q & $past(src3, 2)) == $past(src3, 2); endproperty
  a_keep3: assert property (p_keep3) else $error("third flag lost");
  property p_clr2; r2 && src2 == '0 ##1 r2 && src2 == '0 |=> rdata_q == 8'h00; endproperty
  a_clr2: assert property (p_clr2) else $error("second not cleared");
  property p_clr3; r3 && src3 == '0 ##1 r3 && src3 == '0 |=> rdata_q == 8'h00; endproperty
  a_clr3: assert property (p_clr3) else $error("third not cleared");
  // Reset must win even though the other checks are off during it
  property p_rst; disable iff (1'b0) rst |=> rdata_q == FSM_RST_FLAGS; endproperty
  a_rst: assert property (p_rst) else $error("reset value wrong");
  property p_wr; req.wr && !req.rd |=> $stable(rdata_q); endproperty
  a_wr: assert property (p_wr) else $error("write moved data");
  property p_unmap; req.rd && !hit |=> rdata_q == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_hit; hit == (req.addr == FSM_OFS_SECOND || req.addr == FSM_OFS_THIRD); endproperty
  a_hit: assert property (p_hit) else $error("hit decode wrong");
  c_pair: cover property (r2 ##1 r2);
  c_keep: cover property (r3 && src3 != '0);
  c_wr: cover property (req.wr);
endmodule : fsm_status_mirror_monitor
bind fsm_status_mirror fsm_status_mirror_monitor i_mon (.clk_sys(clk_sys), .rst(rst), .src2(src2), .src3(src3),
  .req(req), .rdata_q(rdata_q), .hit(hit));

// ---- verification/fsm_host_model.sv ----
// Host model putting bench commands onto the register port.
`timescale 1ns/1ps
module fsm_host_model (
  // Clock
  input wire logic              clk_sys,
  // Command in, request out
  input wire fsm_pkg::fsm_req_s cmd,
  output fsm_pkg::fsm_req_s     req
);
  import fsm_pkg::*;
  fsm_req_s held = '0;
  // Launched on the edge so a strobe never moves near the design's sampling point
  always @(posedge clk_sys) held <= cmd;
  assign req = held;
endmodule : fsm_host_model

// ---- verification/fsm_status_mirror_tb.sv ----
// Random bench for the fault status mirror behind the host model.
`timescale 1ns/1ps
module fsm_status_mirror_tb;
  import fsm_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  fsm_src2_s   src2 = '0;
  fsm_src3_s   src3 = '0;
  fsm_req_s    cmd = '0;
  fsm_req_s    req;
  logic [7:0]  rdata_q;
  logic        hit;
  logic [31:0] seed = 32'h0000_0035;                                     // Xorshift start, 53
  int          num_errors = 0;
  int          checks = 0;
  fsm_status_mirror i_dut (.clk_sys(clk_sys), .rst(rst), .src2(src2), .src3(src3), .req(req),
    .rdata_q(rdata_q), .hit(hit));
  fsm_host_model i_host (.clk_sys(clk_sys), .cmd(cmd), .req(req));
  // Clock, 4 ns period
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  // Xorshift stimulus, repeatable from its fixed start
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  // A pulsed and a held fault both leave their flags
  function automatic logic [7:0] f_flags(logic [7:0] p, logic [7:0] h);
    return p | h;
  endfunction : f_flags
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checks++;
    if (seen !== want) begin
      num_errors++;
      $display("Error at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check
  // Hold a command n cycles, check hit, then the answer of the last read
  task automatic op(input fsm_req_s c, input logic [7:0] want, input int n);
    cmd = c;
    repeat (n) @(posedge clk_sys) #1;
    check({7'h00, hit}, {7'h00, c.addr == FSM_OFS_SECOND || c.addr == FSM_OFS_THIRD});
    cmd = '0;
    @(posedge clk_sys) #1;
    if (c.rd) check(rdata_q, want);
  endtask : op
  task automatic conclude();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : conclude
  // Watchdog far beyond the roughly 580 cycles of the run
  initial begin
    #80000;
    num_errors++;
    conclude();
  end
  // Reset, then pulse, hold and drop faults on each register in turn
  initial begin
    fsm_req_s   r;
    logic [7:0] x;
    logic [7:0] y;
    repeat (16) @(posedge clk_sys);
    #1 rst = 1'b0;
    op('{1'b1, 1'b0, FSM_OFS_SECOND, 8'h00}, FSM_RST_FLAGS, 1);
    op('{1'b1, 1'b0, FSM_OFS_THIRD, 8'h00}, FSM_RST_FLAGS, 1);
    for (int i = 0; i < 40; i++) begin
      r = '{1'b1, 1'b0, i[0] ? FSM_OFS_THIRD : FSM_OFS_SECOND, 8'h00};
      x = i < 4 ? 8'hff : rnd();
      y = i < 2 ? 8'h00 : rnd();
      {src2, src3} = i[0] ? {8'h00, x} : {x, 8'h00};
      @(posedge clk_sys) #1;
      {src2, src3} = i[0] ? {8'h00, y} : {y, 8'h00};
      op('{1'b0, 1'b1, r.addr, rnd()}, 8'h00, 1);
      op('{1'b1, 1'b0, {1'b1, x[6:0]}, 8'h00}, 8'h00, 1);
      op(r, f_flags(x, y), 1);
      op(r, y, 1);
      {src2, src3} = 16'h0000;
      op(r, y, 1);
      op(r, 8'h00, 2);
      $display("test %0d done", i);
    end
    conclude();
  end
endmodule : fsm_status_mirror_tb
